// ### tb/test_led_status_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "led_status_cfg.svh"

module test_led_status_control;
  import led_status_pkg::*;
  typedef struct packed
  {
    port_t port;
    logic lp;
    logic [1:0] dup;
    logic fdl;
    logic second_led_pin;
    logic comb;
  } row_t;
  logic CLOCK, RST, AVS_READ, AVS_WRITE, LINK_PASS, WAKE_FRAME, RECEIVE_ACTIVITY;
  logic AVS_WAITREQUEST, FIRST_LED_PIN, SECOND_LED_PIN, IRQ;
  logic [7:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
  port_t ACTIVE_PORT;
  int err_count = 0;
  int checks = 0;
  int a, b, i;
  row_t rows [9];

  led_status_control #(.STRETCH_CYCLES(8)) led_status_control_inst (
    .CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .LINK_PASS(LINK_PASS), .WAKE_FRAME(WAKE_FRAME),
    .RECEIVE_ACTIVITY(RECEIVE_ACTIVITY), .ACTIVE_PORT(ACTIVE_PORT),
    .FIRST_LED_PIN(FIRST_LED_PIN), .SECOND_LED_PIN(SECOND_LED_PIN), .IRQ(IRQ));

  // ==========================================================
  // clock
  initial
  begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end

  // ==========================================================
  // helpers
  task summarize;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    @(posedge CLOCK);
    AVS_ADDRESS <= adr;
    AVS_WRITEDATA <= wd;
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    for (n = 0; n < 20; n++)
    begin
      @(posedge CLOCK);
      if (AVS_WAITREQUEST === 1'b0)
        break;
    end
    if (n == 20)
    begin
      err_count++;
      summarize();
    end
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  // receive pulses at cycle 0 and at gap; counts lit cycles
  task run(input int gap, output int len);
    int k;
    len = 0;
    for (k = 0; k < 40; k++)
    begin
      @(posedge CLOCK);
      RECEIVE_ACTIVITY <= (k == 0 || (gap > 0 && k == gap));
      if (SECOND_LED_PIN === 1'b1)
        len++;
    end
  endtask

  // ==========================================================
  // sequence
  initial
  begin
    RST = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 8'h00;
    AVS_WRITEDATA = 32'h0;
    LINK_PASS = 1'b0;
    WAKE_FRAME = 1'b0;
    RECEIVE_ACTIVITY = 1'b0;
    ACTIVE_PORT = PORT_TWISTED_PAIR;
    rows[0] = '{PORT_TWISTED_PAIR, 1'b1, 2'h1, 1'b1, 1'b0, 1'b1};
    rows[1] = '{PORT_TWISTED_PAIR, 1'b1, 2'h0, 1'b1, 1'b1, 1'b0};
    rows[2] = '{PORT_TWISTED_PAIR, 1'b1, 2'h3, 1'b1, 1'b1, 1'b1};
    rows[3] = '{PORT_TWISTED_PAIR, 1'b0, 2'h1, 1'b1, 1'b0, 1'b0};
    rows[4] = '{PORT_TWISTED_PAIR, 1'b1, 2'h1, 1'b0, 1'b1, 1'b0};
    rows[5] = '{PORT_ATTACHMENT, 1'b0, 2'h3, 1'b1, 1'b0, 1'b1};
    rows[6] = '{PORT_ATTACHMENT, 1'b0, 2'h1, 1'b1, 1'b0, 1'b0};
    rows[7] = '{PORT_GENERIC_SERIAL, 1'b0, 2'h1, 1'b1, 1'b0, 1'b1};
    rows[8] = '{PORT_GENERIC_SERIAL, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0};
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    for (i = 0; i < 9; i++)
    begin
      ACTIVE_PORT <= rows[i].port;
      LINK_PASS <= rows[i].lp;
      bus(1'b1, `LED_REG_SELECT, {23'h0, rows[i].fdl, 8'h0});
      bus(1'b1, `LED_REG_DUPLEX, {30'h0, rows[i].dup});
      bus(1'b0, `LED_REG_LINK, 32'h0);
      check(rd, {16'h0, rows[i].second_led_pin, 15'h0});
      bus(1'b0, `LED_REG_SELECT, 32'h0);
      check(rd, {16'h0, rows[i].comb, 6'h0, rows[i].fdl, 8'h0});
      check(FIRST_LED_PIN, rows[i].second_led_pin);
      check(SECOND_LED_PIN, rows[i].comb);
    end
    $display("test link and duplex rows done");
    RST <= 1'b1;
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    bus(1'b0, `LED_REG_SELECT, 32'h0);
    check(rd, 32'h0000_0084);
    bus(1'b0, `LED_REG_DUPLEX, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, `LED_REG_IRQ_MASK, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 8'hfc, 32'hffff);
    bus(1'b0, 8'hfc, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, `LED_REG_SELECT, 32'hffff_83ff);
    bus(1'b0, `LED_REG_SELECT, 32'h0);
    check(rd, 32'h0000_0384);
    $display("test reset and registers done");
    bus(1'b1, `LED_REG_SELECT, 32'h200);
    bus(1'b1, `LED_REG_IRQ_STATUS, 32'h3);
    @(posedge CLOCK);
    WAKE_FRAME <= 1'b1;
    @(posedge CLOCK);
    WAKE_FRAME <= 1'b0;
    @(posedge CLOCK);
    @(posedge CLOCK);
    check(SECOND_LED_PIN, 1'b1);
    check(IRQ, 1'b0);
    bus(1'b0, `LED_REG_IRQ_STATUS, 32'h0);
    check(rd, 32'h1);
    bus(1'b1, `LED_REG_IRQ_MASK, 32'h1);
    bus(1'b0, `LED_REG_IRQ_MASK, 32'h0);
    check(IRQ, 1'b1);
    bus(1'b1, `LED_REG_IRQ_STATUS, 32'h1);
    bus(1'b0, `LED_REG_IRQ_STATUS, 32'h0);
    check(rd, 32'h0);
    check(IRQ, 1'b0);
    bus(1'b1, `LED_REG_IRQ_MASK, 32'h2);
    LINK_PASS <= 1'b1;
    repeat (2) @(posedge CLOCK);
    bus(1'b0, `LED_REG_IRQ_STATUS, 32'h0);
    check(rd, 32'h2);
    check(IRQ, 1'b1);
    $display("test wake and interrupt done");
    LINK_PASS <= 1'b0;
    bus(1'b1, `LED_REG_SELECT, 32'h84);
    run(0, a);
    check((a >= 9 && a <= 10), 1'b1);
    run(6, b);
    check(b - a, 32'h6);
    bus(1'b1, `LED_REG_SELECT, 32'h4);
    run(0, a);
    check(a, 32'h1);
    $display("test stretch done");
    summarize();
  end
endmodule

`default_nettype wire

// ### verilog/led_status_cfg.svh
`ifndef LED_STATUS_CFG_SVH
`define LED_STATUS_CFG_SVH

// ==========================================================================
// register offsets (byte addresses)
`define LED_REG_LINK 8'h00
`define LED_REG_SELECT 8'h04
`define LED_REG_DUPLEX 8'h08
`define LED_REG_IRQ_STATUS 8'h0c
`define LED_REG_IRQ_MASK 8'h10

// ==========================================================================
// field positions
`define LINK_GOOD_BIT 15
`define SEL_COMBINED_BIT 15
`define SEL_RSVD_HI 14
`define SEL_RSVD_LO 10
`define SEL_WAKE_BIT 9
`define SEL_FDLINK_BIT 8
`define SEL_STRETCH_BIT 7
`define SEL_RCV_BIT 2
`define DUP_FULL_DUPLEX_ENABLE_BIT 0
`define DUP_ATTACHMENT_PORT_FULL_DUPLEX_BIT 1
`define IRQ_WAKE_BIT 0
`define IRQ_LINK_BIT 1

// ==========================================================================
// reset values
`define SEL_RESET_RCV 1'b1
`define SEL_RESET_STRETCH 1'b1
`define DUPLEX_RESET 2'h0
`define IRQ_MASK_RESET 2'h0

// ==========================================================================
// timing
`define CLOCK_PERIOD_NS 4
`define LED_STRETCH_TIME_US 50000
`define LED_STRETCH_CYCLES ((`LED_STRETCH_TIME_US * 1000) / `CLOCK_PERIOD_NS)

`endif

// ### verilog/led_status_control.sv
// Behaviour
// - bit 15 reads unstretched combined source state
// - select bits 14-10 read zero
// - wake frame lights second LED when enabled
// - full-duplex link source adds to combined
// - twisted pair: link pass and duplex enable
// - attachment port: both duplex enables set
// - generic serial port: duplex enable set
// - stretch enable lengthens each source occurrence
// - first LED shows link pass unless masked by the full-duplex link display
// - link register bit 15 mirrors link LED
// - link LED masked under full-duplex link display; the code masks it only on twisted pair with attachment full duplex clear
// - one link LED lit, by duplex enable; both lit on twisted pair when attachment full duplex is also set; the code also lights both on attachment and serial ports
// - link register bits 14-0 reserved
// - second LED is OR of enabled sources
// - reset selects receive activity, stretch on
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "led_status_cfg.svh"

module led_status_control #(
  parameter int unsigned STRETCH_CYCLES = `LED_STRETCH_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic LINK_PASS,
  input wire logic WAKE_FRAME,
  input wire logic RECEIVE_ACTIVITY,
  input wire led_status_pkg::port_t ACTIVE_PORT,
  output logic FIRST_LED_PIN,
  output logic SECOND_LED_PIN,
  output logic IRQ
);
  import led_status_pkg::*;

  // ========================================================================
  // state
  led_select_t sel;
  led_select_t next_sel;
  duplex_control_t duplex;
  duplex_control_t next_duplex;
  irq_bits_t irq_status;
  irq_bits_t next_irq_status;
  irq_bits_t irq_mask;
  irq_bits_t next_irq_mask;
  logic combined_q;
  logic next_irq;
  logic link_led_prev;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic accept_write;
  logic accept_read;
  logic is_tp;
  logic is_aui;
  logic is_generic_serial_port;
  logic fd_link_source;
  logic combined_indicator_state;
  logic link_good_indicator;
  logic stretched;
  logic [15:0] select_word;
  logic [15:0] link_word;

  // ========================================================================
  // indicator sources
  always_comb
  begin
    is_tp = (ACTIVE_PORT == PORT_TWISTED_PAIR);
    is_aui = (ACTIVE_PORT == PORT_ATTACHMENT);
    is_generic_serial_port = (ACTIVE_PORT == PORT_GENERIC_SERIAL);
    fd_link_source = 1'b0;
    if (is_tp)
    begin
      fd_link_source = LINK_PASS & duplex.full_duplex_enable;
    end
    else if (is_aui)
    begin
      fd_link_source = duplex.full_duplex_enable & duplex.attachment_port_full_duplex;
    end
    else if (is_generic_serial_port)
    begin
      fd_link_source = duplex.full_duplex_enable;
    end
    combined_indicator_state = (sel.wake_frame_led_enable & WAKE_FRAME)
      | (sel.full_duplex_link_led_enable & fd_link_source)
      | (sel.receive_activity_enable & RECEIVE_ACTIVITY);
    // full-duplex display takes over from the half-duplex link LED
    link_good_indicator = LINK_PASS
      & ~(is_tp & duplex.full_duplex_enable
      & ~duplex.attachment_port_full_duplex & sel.full_duplex_link_led_enable);
  end

  pulse_stretcher #(
    .CYCLES(STRETCH_CYCLES)
  ) pulse_stretcher_inst (
    .clock(CLOCK),
    .rst(RST),
    .enable(sel.stretch_enable),
    .level(combined_indicator_state),
    .held(stretched)
  );

  // ========================================================================
  // avalon slave: one wait state per access
  always_comb
  begin
    accept_write = AVS_WRITE & ~AVS_WAITREQUEST;
    accept_read = AVS_READ & ~AVS_WAITREQUEST;
    next_waitrequest = ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
    link_word = 16'h0000;
    link_word[`LINK_GOOD_BIT] = FIRST_LED_PIN;
    select_word = 16'h0000;
    select_word[`SEL_COMBINED_BIT] = combined_q;
    select_word[`SEL_WAKE_BIT] = sel.wake_frame_led_enable;
    select_word[`SEL_FDLINK_BIT] = sel.full_duplex_link_led_enable;
    select_word[`SEL_STRETCH_BIT] = sel.stretch_enable;
    select_word[`SEL_RCV_BIT] = sel.receive_activity_enable;
    next_readdata = AVS_READDATA;
    if (AVS_READ & AVS_WAITREQUEST)
    begin
      unique case (AVS_ADDRESS)
        `LED_REG_LINK: next_readdata = {16'h0000, link_word};
        `LED_REG_SELECT: next_readdata = {16'h0000, select_word};
        `LED_REG_DUPLEX: next_readdata = {30'h0, duplex};
        `LED_REG_IRQ_STATUS: next_readdata = {30'h0, irq_status};
        `LED_REG_IRQ_MASK: next_readdata = {30'h0, irq_mask};
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // software-written registers and interrupt status
  always_comb
  begin
    next_sel = sel;
    next_duplex = duplex;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (accept_write)
    begin
      unique case (AVS_ADDRESS)
        `LED_REG_SELECT:
        begin
          next_sel.wake_frame_led_enable = AVS_WRITEDATA[`SEL_WAKE_BIT];
          next_sel.full_duplex_link_led_enable = AVS_WRITEDATA[`SEL_FDLINK_BIT];
          next_sel.stretch_enable = AVS_WRITEDATA[`SEL_STRETCH_BIT];
          next_sel.receive_activity_enable = AVS_WRITEDATA[`SEL_RCV_BIT];
        end
        `LED_REG_DUPLEX:
        begin
          next_duplex.full_duplex_enable = AVS_WRITEDATA[`DUP_FULL_DUPLEX_ENABLE_BIT];
          next_duplex.attachment_port_full_duplex = AVS_WRITEDATA[`DUP_ATTACHMENT_PORT_FULL_DUPLEX_BIT];
        end
        `LED_REG_IRQ_STATUS:
        begin
          next_irq_status.wake_frame_seen = irq_status.wake_frame_seen
            & ~AVS_WRITEDATA[`IRQ_WAKE_BIT];
          next_irq_status.link_changed = irq_status.link_changed
            & ~AVS_WRITEDATA[`IRQ_LINK_BIT];
        end
        `LED_REG_IRQ_MASK:
        begin
          next_irq_mask.wake_frame_seen = AVS_WRITEDATA[`IRQ_WAKE_BIT];
          next_irq_mask.link_changed = AVS_WRITEDATA[`IRQ_LINK_BIT];
        end
        default:
        begin
        end
      endcase
    end
    // new events win over a clear in the same cycle
    if (WAKE_FRAME)
    begin
      next_irq_status.wake_frame_seen = 1'b1;
    end
    if (FIRST_LED_PIN != link_led_prev)
    begin
      next_irq_status.link_changed = 1'b1;
    end
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      sel.wake_frame_led_enable <= 1'b0;
      sel.full_duplex_link_led_enable <= 1'b0;
      sel.stretch_enable <= `SEL_RESET_STRETCH;
      sel.receive_activity_enable <= `SEL_RESET_RCV;
      duplex <= `DUPLEX_RESET;
      irq_mask <= `IRQ_MASK_RESET;
      irq_status <= '0;
      IRQ <= 1'b0;
      AVS_READDATA <= 32'h0000_0000;
      AVS_WAITREQUEST <= 1'b1;
      combined_q <= 1'b0;
      FIRST_LED_PIN <= 1'b0;
      SECOND_LED_PIN <= 1'b0;
      link_led_prev <= 1'b0;
    end
    else
    begin
      sel <= next_sel;
      duplex <= next_duplex;
      irq_mask <= next_irq_mask;
      irq_status <= next_irq_status;
      IRQ <= next_irq;
      AVS_READDATA <= next_readdata;
      AVS_WAITREQUEST <= next_waitrequest;
      combined_q <= combined_indicator_state;
      FIRST_LED_PIN <= link_good_indicator;
      SECOND_LED_PIN <= stretched;
      link_led_prev <= FIRST_LED_PIN;
    end
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  sequence s_event_ends;
    (sel.stretch_enable && combined_indicator_state)
      ##1 (sel.stretch_enable && !combined_indicator_state);
  endsequence

  sequence s_select_read_done;
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `LED_REG_SELECT;
  endsequence

  a_bus_one_wait: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("access not answered after one wait cycle");

  a_combined_readback: assert property (
    s_select_read_done |-> AVS_READDATA[`SEL_COMBINED_BIT] == $past(combined_q))
    else $error("combined bit readback wrong");

  a_select_reserved_zero: assert property (
    s_select_read_done |-> AVS_READDATA[`SEL_RSVD_HI:`SEL_RSVD_LO] == 5'h00)
    else $error("reserved select bits not zero");

  a_wake_lights_led: assert property (
    sel.wake_frame_led_enable && WAKE_FRAME |-> ##2 SECOND_LED_PIN)
    else $error("wake frame did not light second led");

  a_tp_fd_source: assert property (
    sel.full_duplex_link_led_enable && is_tp && LINK_PASS
      && duplex.full_duplex_enable |=> combined_q)
    else $error("twisted pair full duplex source missing");

  a_aui_fd_source: assert property (
    sel.full_duplex_link_led_enable && is_aui && duplex.full_duplex_enable
      && duplex.attachment_port_full_duplex |=> combined_q)
    else $error("attachment port full duplex source missing");

  a_generic_serial_port_fd_source: assert property (
    sel.full_duplex_link_led_enable && is_generic_serial_port && duplex.full_duplex_enable |=> combined_q)
    else $error("serial port full duplex source missing");

  a_stretch_holds: assert property (
    s_event_ends |-> ##2 SECOND_LED_PIN)
    else $error("stretched led dropped too early");

  a_no_source_dark: assert property (
    !(sel.wake_frame_led_enable && WAKE_FRAME)
      && !(sel.full_duplex_link_led_enable && fd_link_source)
      && !(sel.receive_activity_enable && RECEIVE_ACTIVITY) |=> !combined_q)
    else $error("combined state set with no enabled source");

  a_link_led_follows: assert property (
    LINK_PASS && !sel.full_duplex_link_led_enable |=> FIRST_LED_PIN)
    else $error("link led not lit on link pass");

  a_link_readback: assert property (
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `LED_REG_LINK
      |-> AVS_READDATA[`LINK_GOOD_BIT] == $past(FIRST_LED_PIN))
    else $error("link bit readback wrong");

  a_link_masked: assert property (
    is_tp && duplex.full_duplex_enable && !duplex.attachment_port_full_duplex
      && sel.full_duplex_link_led_enable |=> !FIRST_LED_PIN)
    else $error("link led not masked in full duplex display");

  a_reset_select: assert property (
    $past(RST) |-> sel.receive_activity_enable && sel.stretch_enable)
    else $error("select register reset value wrong");

  a_irq_level: assert property (
    (|(irq_status & irq_mask)) |-> ##[0:1] IRQ)
    else $error("interrupt not raised for unmasked status");

endmodule

`default_nettype wire

// ### verilog/led_status_pkg.sv
`default_nettype none

package led_status_pkg;

  typedef enum logic [1:0] {PORT_TWISTED_PAIR, PORT_ATTACHMENT, PORT_GENERIC_SERIAL} port_t;

  typedef struct packed {
    logic wake_frame_led_enable;
    logic full_duplex_link_led_enable;
    logic stretch_enable;
    logic receive_activity_enable;
  } led_select_t;

  typedef struct packed {
    logic attachment_port_full_duplex;
    logic full_duplex_enable;
  } duplex_control_t;

  typedef struct packed {
    logic link_changed;
    logic wake_frame_seen;
  } irq_bits_t;

endpackage

`default_nettype wire

// ### verilog/pulse_stretcher.sv
`timescale 1ns/1ns
`default_nettype none

module pulse_stretcher #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic level,
  output logic held
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_held;

  // ========================================================================
  // restartable hold counter
  always_comb
  begin
    next_count = count;
    if (level)
    begin
      next_count = W'(CYCLES);
    end
    else if (count != '0)
    begin
      next_count = count - W'(1);
    end
    next_held = level | (enable & (count != '0));
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      count <= '0;
      held <= 1'b0;
    end
    else
    begin
      count <= next_count;
      held <= next_held;
    end
  end

endmodule

`default_nettype wire
